// ==== rtl/ddac_pkg.sv ====
package ddac_pkg;
  // slave address upper six bits; arbitrary neutral value, the strap supplies bit 0
  localparam logic [5:0]  ADDR_PRESET    = 6'h1c;
  localparam int          CODE_W         = 12;
  localparam logic [11:0] CODE_ZERO      = 12'h000;
  localparam logic [1:0]  PD_UP          = 2'h0;
  localparam logic [1:0]  PD_FLOAT       = 2'h1;
  localparam logic [1:0]  PD_1K          = 2'h2;
  localparam logic [1:0]  PD_100K        = 2'h3;
  localparam logic [1:0]  PD_RESET       = PD_100K;
  localparam logic [3:0]  BIT_LAST       = 4'h7;
  localparam logic [3:0]  BIT_ACK        = 4'h8;
  // command nibble codes
  localparam logic [3:0]  CMD_LDA_UPD    = 4'h0;
  localparam logic [3:0]  CMD_LDB_UPD    = 4'h1;
  localparam logic [3:0]  CMD_LDA_IN     = 4'h4;
  localparam logic [3:0]  CMD_LDB_IN     = 4'h5;
  localparam logic [3:0]  CMD_UPD_LDA    = 4'h8;
  localparam logic [3:0]  CMD_UPD_LDB    = 4'h9;
  localparam logic [3:0]  CMD_LDALL_UPD  = 4'hc;
  localparam logic [3:0]  CMD_LDALL_IN   = 4'hd;
  localparam logic [3:0]  CMD_UPD_ALL    = 4'he;
  localparam logic [3:0]  CMD_EXT        = 4'hf;
  // extended byte: bit 0 selects a, bit 1 selects b, bits 7:6 carry the mode
  localparam int          EXT_SEL_A      = 0;
  localparam int          EXT_SEL_B      = 1;
  localparam int          EXT_PD_LO      = 6;
  localparam int          EXT_PD_HI      = 7;
  typedef enum logic [2:0] {
    DDAC_IDLE  = 3'b000,
    DDAC_ADDR  = 3'b001,
    DDAC_CMD   = 3'b010,
    DDAC_DATA  = 3'b011,
    DDAC_EXT   = 3'b100,
    DDAC_READ  = 3'b101
  } ddac_state_e;
endpackage

// ==== rtl/ddac_sync.sv ====
`timescale 1ns/10ps
`default_nettype none
// three-stage synchroniser; a change counts once stages two and three agree
module ddac_sync (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic d,
  output logic      q
);
  logic [2:0] sh_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sh_reg <= 3'h7;
    end else begin
      sh_reg <= {sh_reg[1:0], d};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= 1'b1;
    end else if (sh_reg[1] == sh_reg[2]) begin
      q <= sh_reg[2];
    end
  end
endmodule
`default_nettype wire

// ==== rtl/ddac_ctrl.sv ====
`timescale 1ns/10ps
`default_nettype none
module ddac_ctrl (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     scl_in,
  input  wire logic                     sda_in,
  output logic                          sda_out,
  output logic                          sda_oe,
  input  wire logic                     addr_sel,
  output logic [ddac_pkg::CODE_W-1:0]   channel_a_output,
  output logic [ddac_pkg::CODE_W-1:0]   channel_b_output,
  output logic [1:0]                    powerdown_mode_a,
  output logic [1:0]                    powerdown_mode_b,
  output logic                          buffer_en_a,
  output logic                          buffer_en_b,
  output logic                          busy
);
  import ddac_pkg::*;

  // ----------------------------------------
  // pin sampling and bus conditions
  // ----------------------------------------
  logic scl_s, sda_s, sel_s, scl_d_reg, sda_d_reg;
  logic scl_rise, scl_fall, start_det, stop_det;

  // bus clock is only ever sampled, never driven
  ddac_sync u_scl (.clk(clk), .rst(rst), .d(scl_in), .q(scl_s));
  ddac_sync u_sda (.clk(clk), .rst(rst), .d(sda_in), .q(sda_s));
  ddac_sync u_sel (.clk(clk), .rst(rst), .d(addr_sel), .q(sel_s));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  assign scl_rise  = scl_s & ~scl_d_reg;
  assign scl_fall  = ~scl_s & scl_d_reg;
  assign start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign stop_det  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  // ----------------------------------------
  // bit counter and shifter
  // ----------------------------------------
  ddac_state_e     state_reg;
  logic [3:0]      bit_reg;
  logic [7:0]      shift_reg;
  logic            rw_reg;
  logic            nack_reg;
  logic            stop_armed_reg;
  logic [3:0]      cmd_reg;
  logic [3:0]      hi_reg;
  logic            byte2_reg;
  logic            rbyte_reg;
  logic [CODE_W-1:0] in_a_reg, in_b_reg;
  logic            ack_phase, byte_done;

  assign ack_phase = (bit_reg == BIT_ACK);
  assign byte_done = ack_phase & scl_fall;

  function automatic logic addr_match(input logic [7:0] b, input logic sel);
    // only the exact 7-bit address; general call never matches
    return (b[7:1] == {ADDR_PRESET, sel});
  endfunction

  // stop is ignored inside the same high pulse that carried a start
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stop_armed_reg <= 1'b0;
    end else if (start_det) begin
      stop_armed_reg <= 1'b0;
    end else if (scl_fall) begin
      stop_armed_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bit_reg   <= 4'h0;
      shift_reg <= 8'h00;
    end else if (start_det || state_reg == DDAC_IDLE) begin
      bit_reg   <= 4'h0;
    end else if (scl_rise && !ack_phase) begin
      shift_reg <= {shift_reg[6:0], sda_s};
    end else if (scl_fall && stop_armed_reg) begin
      // the fall that closes a start is not a data bit
      bit_reg   <= ack_phase ? 4'h0 : bit_reg + 4'h1;
    end
  end

  // ----------------------------------------
  // transfer sequencer
  // ----------------------------------------
  logic upd_a, upd_b, ld_a, ld_b, ld_ext;
  logic [CODE_W-1:0] wdata;
  assign wdata = {hi_reg, shift_reg};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= DDAC_IDLE;
      rw_reg    <= 1'b0;
      cmd_reg   <= 4'h0;
      hi_reg    <= 4'h0;
      byte2_reg <= 1'b0;
      rbyte_reg <= 1'b0;
      nack_reg  <= 1'b0;
    end else if (start_det) begin
      state_reg <= DDAC_ADDR;
    end else if (stop_det && stop_armed_reg) begin
      state_reg <= DDAC_IDLE;
    end else if (byte_done) begin
      case (state_reg)
        DDAC_ADDR: begin
          if (addr_match(shift_reg, sel_s)) begin
            rw_reg    <= shift_reg[0];
            rbyte_reg <= 1'b0;
            state_reg <= shift_reg[0] ? DDAC_READ : DDAC_CMD;
          end else begin
            state_reg <= DDAC_IDLE;
          end
        end
        DDAC_CMD: begin
          cmd_reg   <= shift_reg[7:4];
          hi_reg    <= shift_reg[3:0];
          byte2_reg <= 1'b0;
          if (shift_reg[7:4] == CMD_EXT && shift_reg[3:0] == 4'h0) begin
            state_reg <= DDAC_EXT;
          end else if (shift_reg[7:4] == CMD_UPD_ALL) begin
            state_reg <= DDAC_CMD; // update-only, no data byte follows
          end else begin
            state_reg <= DDAC_DATA;
          end
        end
        DDAC_DATA: state_reg <= DDAC_CMD;
        DDAC_EXT:  state_reg <= DDAC_CMD;
        DDAC_READ: begin
          rbyte_reg <= ~rbyte_reg;
          if (nack_reg) begin
            state_reg <= DDAC_IDLE;
          end
        end
        default:   state_reg <= DDAC_IDLE;
      endcase
    end else if (scl_rise && ack_phase) begin
      nack_reg <= sda_s;
    end
  end

  // ----------------------------------------
  // command decode, committed on ack falling edge
  // ----------------------------------------
  always_comb begin
    upd_a  = 1'b0;
    upd_b  = 1'b0;
    ld_a   = 1'b0;
    ld_b   = 1'b0;
    ld_ext = 1'b0;
    if (byte_done && state_reg == DDAC_CMD && shift_reg[7:4] == CMD_UPD_ALL) begin
      upd_a = 1'b1;
      upd_b = 1'b1;
    end
    if (byte_done && state_reg == DDAC_EXT) begin
      ld_ext = 1'b1;
    end
    if (byte_done && state_reg == DDAC_DATA) begin
      case (cmd_reg)
        CMD_LDA_UPD, CMD_LDB_UPD, CMD_UPD_LDA, CMD_UPD_LDB: begin
          ld_a  = (cmd_reg[0] == 1'b0);
          ld_b  = (cmd_reg[0] == 1'b1);
          upd_a = 1'b1;
          upd_b = 1'b1;
        end
        CMD_LDA_IN:    ld_a = 1'b1;
        CMD_LDB_IN:    ld_b = 1'b1;
        CMD_LDALL_UPD: begin
          ld_a  = 1'b1;
          ld_b  = 1'b1;
          upd_a = 1'b1;
          upd_b = 1'b1;
        end
        CMD_LDALL_IN: begin
          ld_a = 1'b1;
          ld_b = 1'b1;
        end
        default: begin
          ld_a = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // input and converter registers
  // ----------------------------------------
  // new input data bypasses into the converter register in the same edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      in_a_reg         <= CODE_ZERO;
      in_b_reg         <= CODE_ZERO;
      channel_a_output <= CODE_ZERO;
      channel_b_output <= CODE_ZERO;
    end else begin
      if (ld_a) in_a_reg <= wdata;
      if (ld_b) in_b_reg <= wdata;
      if (upd_a) channel_a_output <= ld_a ? wdata : in_a_reg;
      if (upd_b) channel_b_output <= ld_b ? wdata : in_b_reg;
    end
  end

  // ----------------------------------------
  // power state; codes kept through power-down
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      powerdown_mode_a <= PD_RESET;
      powerdown_mode_b <= PD_RESET;
      buffer_en_a      <= 1'b0;
      buffer_en_b      <= 1'b0;
    end else if (ld_ext) begin
      if (shift_reg[EXT_SEL_A]) begin
        powerdown_mode_a <= shift_reg[EXT_PD_HI:EXT_PD_LO];
        buffer_en_a      <= (shift_reg[EXT_PD_HI:EXT_PD_LO] == PD_UP);
      end
      if (shift_reg[EXT_SEL_B]) begin
        powerdown_mode_b <= shift_reg[EXT_PD_HI:EXT_PD_LO];
        buffer_en_b      <= (shift_reg[EXT_PD_HI:EXT_PD_LO] == PD_UP);
      end
    end
  end

  // ----------------------------------------
  // data line driver, low only
  // ----------------------------------------
  // changes on scl falling edges, and is otherwise only released at a start or stop
  logic [CODE_W-1:0] rd_code;
  logic [3:0]        rd_idx;
  logic [15:0]       rd_word;
  logic              rd_low;
  assign rd_code = channel_a_output;
  assign rd_word = {cmd_reg, rd_code};
  // index of the bit driven after this fall; the ack fall opens the other byte
  assign rd_idx  = ack_phase ? BIT_LAST : (BIT_LAST - 4'h1 - bit_reg);
  assign rd_low  = ack_phase ? ~rbyte_reg : rbyte_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sda_out <= 1'b0;
      sda_oe  <= 1'b0;
      busy    <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      busy    <= (state_reg != DDAC_IDLE);
      if (start_det || (stop_det && stop_armed_reg)) begin
        sda_oe <= 1'b0;
      end else if (scl_fall) begin
        if (bit_reg == BIT_LAST && state_reg != DDAC_READ && state_reg != DDAC_IDLE) begin
          sda_oe <= (state_reg != DDAC_ADDR) || addr_match(shift_reg, sel_s);
        end else if (state_reg == DDAC_READ && bit_reg == BIT_LAST) begin
          sda_oe <= 1'b0;
        end else if (state_reg == DDAC_READ && !(ack_phase && nack_reg)) begin
          sda_oe <= ~rd_word[{~rd_low, rd_idx[2:0]}];
        end else if (byte_done && state_reg == DDAC_ADDR && addr_match(shift_reg, sel_s)
                     && shift_reg[0]) begin
          sda_oe <= ~rd_word[4'hf];
        end else begin
          sda_oe <= 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== verification/ddac_sva.sv ====
`timescale 1ns/10ps
`default_nettype none
module ddac_sva (
  input wire logic                         clk,
  input wire logic                         rst,
  input wire logic                         scl_in,
  input wire logic                         sda_in,
  input wire logic                         sda_out,
  input wire logic                         sda_oe,
  input wire logic                         addr_sel,
  input wire logic [ddac_pkg::CODE_W-1:0]  channel_a_output,
  input wire logic [ddac_pkg::CODE_W-1:0]  channel_b_output,
  input wire logic [1:0]                   powerdown_mode_a,
  input wire logic [1:0]                   powerdown_mode_b,
  input wire logic                         buffer_en_a,
  input wire logic                         buffer_en_b,
  input wire logic                         busy
);
  import ddac_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // raw pin seen high for a while after its low phase
  sequence s_high_phase;
    ##[1:40] scl_in ##1 scl_in[*4];
  endsequence
  a_oe_low_only: assert property (sda_oe |-> !sda_out)
    else $error("data line driven high");
  a_reset_state: assert property (disable iff (1'b0) rst |-> channel_a_output == CODE_ZERO
    && channel_b_output == CODE_ZERO && powerdown_mode_a == PD_RESET && !buffer_en_b
    && powerdown_mode_b == PD_RESET && !buffer_en_a && !sda_oe && !busy)
    else $error("state wrong during reset");
  a_buffer_mode_a: assert property (buffer_en_a == (powerdown_mode_a == PD_UP))
    else $error("buffer a disagrees with mode");
  a_buffer_mode_b: assert property (buffer_en_b == (powerdown_mode_b == PD_UP))
    else $error("buffer b disagrees with mode");
  a_oe_steady_high: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data drive changed with clock high");
  a_code_a_update: assert property ($changed(channel_a_output) |-> busy && !scl_in)
    else $error("code a changed outside ack low");
  a_code_b_update: assert property ($changed(channel_b_output) |-> busy && !scl_in)
    else $error("code b changed outside ack low");
  a_mode_update: assert property ($changed(powerdown_mode_a) || $changed(powerdown_mode_b)
    |-> busy && !scl_in)
    else $error("mode changed outside ack low");
  a_ack_held: assert property ($rose(sda_oe) |-> sda_oe throughout s_high_phase)
    else $error("low drive released early");
endmodule
bind ddac_ctrl ddac_sva u_sva (.clk(clk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .addr_sel(addr_sel),
  .channel_a_output(channel_a_output), .channel_b_output(channel_b_output),
  .powerdown_mode_a(powerdown_mode_a), .powerdown_mode_b(powerdown_mode_b),
  .buffer_en_a(buffer_en_a), .buffer_en_b(buffer_en_b), .busy(busy));
`default_nettype wire

// ==== verification/ddac_master.sv ====
`timescale 1ns/10ps
`default_nettype none
module ddac_master (
  output logic      scl,
  output logic      sda_drv,
  input  wire logic sda_line
);
  // phases are whole system clocks, so every pin change lands on a falling clk edge
  localparam realtime TA = 30.0;
  localparam realtime TB = 35.0;
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // start doubles as repeated start from clock low
  task start;
    sda_drv = 1'b1;
    #TA scl = 1'b1;
    #TB sda_drv = 1'b0;
    #TA scl = 1'b0;
    #TA;
  endtask
  task stop;
    sda_drv = 1'b0;
    #TA scl = 1'b1;
    #TB sda_drv = 1'b1;
    #(4*TA);
  endtask
  // data moves mid-low, sampled mid-high; start and stop drive the clock too
  task bitx(input logic b, output logic r);
    sda_drv = b;
    #TA scl = 1'b1;
    #TB r = sda_line;
    #TA scl = 1'b0;
    #TA;
  endtask
  task wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], r);
    end
    bitx(1'b1, ack);
  endtask
  task rbyte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, d[i]);
    end
    bitx(nack, r);
  endtask
endmodule
`default_nettype wire

// ==== verification/tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import ddac_pkg::*;
  logic clk, rst, addr_sel, scl, sda_drv, sda_out, sda_oe, bf_a, bf_b, busy;
  logic [11:0] ch_a, ch_b;
  logic [1:0]  md_a, md_b;
  logic [7:0]  d;
  int          n_mismatch, samples_checked;
  wire logic   sda_w;
  // open drain with pull-up: anyone pulling low wins
  assign sda_w = ~((sda_oe & ~sda_out) | ~sda_drv);
  ddac_ctrl dut (.clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out),
    .sda_oe(sda_oe), .addr_sel(addr_sel), .channel_a_output(ch_a), .channel_b_output(ch_b),
    .powerdown_mode_a(md_a), .powerdown_mode_b(md_b), .buffer_en_a(bf_a),
    .buffer_en_b(bf_b), .busy(busy));
  ddac_master u_m (.scl(scl), .sda_drv(sda_drv), .sda_line(sda_w));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task chk(input string n, input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", n, exp, got);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task send(input logic [7:0] b, input logic exp_nack);
    logic a;
    u_m.wbyte(b, a);
    chk("ack", a, exp_nack);
  endtask
  task addr(input logic rw, input logic sel, input logic exp_nack);
    u_m.start;
    send({ADDR_PRESET, sel, rw}, exp_nack);
  endtask
  task wr(input logic [7:0] c, input logic [7:0] v, input logic nk);
    addr(1'b0, addr_sel, 1'b0);
    send(c, nk);
    send(v, nk);
    u_m.stop;
  endtask
  initial begin
    #200000;
    n_mismatch++;
    tally_and_finish;
  end
  initial begin
    rst = 1'b1;
    addr_sel = 1'b0;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    repeat (10) @(negedge clk);
    chk("code_a", ch_a, 0);
    chk("mode_b", md_b, PD_RESET);
    chk("buf_a", bf_a, 0);
    // ------------------------------------------------------------
    // loads, then back-to-back with a repeated start
    // ------------------------------------------------------------
    addr(1'b0, 1'b0, 1'b0);
    send({CMD_LDA_UPD, 4'h1}, 1'b0);
    send(8'h23, 1'b0);
    send({CMD_LDB_IN, 4'ha}, 1'b0);
    send(8'hbc, 1'b0);
    u_m.stop;
    chk("code_a", ch_a, 12'h123);
    chk("code_b", ch_b, 0);
    addr(1'b0, 1'b0, 1'b0);
    send({CMD_UPD_ALL, 4'h0}, 1'b0);
    addr(1'b0, 1'b0, 1'b0);
    send({CMD_EXT, 4'h0}, 1'b0);
    send(8'h02, 1'b0);
    u_m.stop;
    chk("code_b", ch_b, 12'habc);
    chk("buf_b", bf_b, 1);
    for (int m = 3; m >= 0; m--) begin
      wr({CMD_EXT, 4'h0}, {m[1:0], 6'h01}, 1'b0);
      chk("mode_a", md_a, m[1:0]);
      chk("buf_a", bf_a, m == 0);
      chk("code_a", ch_a, 12'h123);
    end
    // ------------------------------------------------------------
    // strap, read back, mismatch, retry, abort
    // ------------------------------------------------------------
    @(negedge clk) addr_sel = 1'b1;
    addr(1'b1, 1'b1, 1'b0);
    u_m.rbyte(1'b0, d);
    chk("rd_hi", d[3:0], 4'h1);
    u_m.rbyte(1'b1, d);
    chk("rd_lo", d, 8'h23);
    u_m.stop;
    addr(1'b0, 1'b0, 1'b1);
    send({CMD_LDA_UPD, 4'hf}, 1'b1);
    send(8'hff, 1'b1);
    u_m.stop;
    chk("code_a", ch_a, 12'h123);
    wr({CMD_LDA_UPD, 4'hf}, 8'hff, 1'b0);
    chk("code_a", ch_a, 12'hfff);
    addr(1'b0, 1'b1, 1'b0);
    send({CMD_LDALL_UPD, 4'h5}, 1'b0);
    u_m.stop;
    chk("code_a", ch_a, 12'hfff);
    // ------------------------------------------------------------
    // remaining commands, update-only then command, channel b float
    // ------------------------------------------------------------
    wr({CMD_LDA_IN, 4'h4}, 8'h56, 1'b0);
    chk("code_a", ch_a, 12'hfff);
    wr({CMD_LDB_UPD, 4'h7}, 8'h89, 1'b0);
    chk("code_b", ch_b, 12'h789);
    chk("code_a", ch_a, 12'h456);
    wr({CMD_LDALL_IN, 4'h3}, 8'h21, 1'b0);
    chk("code_b", ch_b, 12'h789);
    wr({CMD_UPD_LDB, 4'h6}, 8'h54, 1'b0);
    chk("code_a", ch_a, 12'h321);
    wr({CMD_UPD_LDA, 4'h0}, 8'h11, 1'b0);
    chk("code_b", ch_b, 12'h654);
    addr(1'b0, 1'b1, 1'b0);
    send({CMD_UPD_ALL, 4'h0}, 1'b0);
    send({CMD_LDA_IN, 4'h7}, 1'b0);
    send(8'h77, 1'b0);
    u_m.stop;
    chk("code_a", ch_a, 12'h011);
    addr(1'b0, 1'b1, 1'b0);
    send({CMD_UPD_ALL, 4'h0}, 1'b0);
    u_m.stop;
    chk("code_a", ch_a, 12'h777);
    wr({CMD_EXT, 4'h0}, {PD_FLOAT, 6'h02}, 1'b0);
    chk("mode_b", md_b, PD_FLOAT);
    chk("buf_b", bf_b, 0);
    chk("code_b", ch_b, 12'h654);
    u_m.start;
    send(8'h00, 1'b1);
    u_m.stop;
    chk("busy", busy, 0);
    tally_and_finish;
  end
endmodule
`default_nettype wire
